/* hw/maprm_pkg.sv */
// Package: register map, field layout and constants of the axis parameter block
package maprm_pkg;
  // Register byte addresses (word aligned)
  localparam logic [4:0] OFS_INTERP_AUX   = 5'h00;
  localparam logic [4:0] OFS_ACCEL_RANGE  = 5'h04;
  localparam logic [4:0] OFS_DECEL_RANGE  = 5'h08;
  localparam logic [4:0] OFS_CORR_SPEED   = 5'h0c;
  localparam logic [4:0] OFS_ENV_ONE      = 5'h10;
  localparam logic [4:0] OFS_STATUS       = 5'h14;
  localparam logic [4:0] OFS_ACCEL_WORK   = 5'h18;
  localparam logic [4:0] OFS_DECEL_WORK   = 5'h1c;
  // Field widths
  localparam int AUX_W   = 28;
  localparam int RANGE_W = 15;
  localparam int SPEED_W = 16;
  localparam int ENV_W   = 8;
  localparam int KIND_W  = 7;
  localparam int MULT_W  = 16;
  // Operation kinds that use the auxiliary register
  localparam logic [6:0] KIND_CLI2 = 7'h62;
  localparam logic [6:0] KIND_LI2  = 7'h63;
  localparam logic [6:0] KIND_CW   = 7'h64;
  localparam logic [6:0] KIND_CCW  = 7'h65;
  // Environment one field positions
  localparam int ENV_FMT_LO = 0;
  localparam int ENV_FMT_HI = 2;
  localparam int ENV_LIMIT  = 3;
  localparam logic [2:0] FMT_TWO_PULSE = 3'h4;
  localparam logic [1:0] FMT_INV_HI    = 2'h1;
  // Reset values
  localparam logic [31:0] RST_WORD  = 32'h0000_0000;
  localparam logic [31:0] BAD_ADDR  = 32'h0000_0000;
  // Aux usage modes
  typedef enum logic [2:0] {
    AUX_NONE   = 3'b001,
    AUX_MASTER = 3'b010,
    AUX_CENTER = 3'b100
  } maprm_aux_type;
endpackage : maprm_pkg

/* hw/maprm_top.sv */
// Axis parameter registers: pre-registers, working copies, correction speed, env one
// Operation
// - The auxiliary pre-register matters only for kinds 62h to 65h.
// - In both linear interpolation 2 kinds the auxiliary value is a master axis feed.
// - In circular kinds the auxiliary value is a signed 28-bit arc centre offset.
// - The top four auxiliary bits ignore writes and read as copies of bit 27.
// - The aux and both curve range parameters each have a pre-register and a working register of the same layout.
// - The acceleration curve range keeps only fifteen bits, normally 1 to 32767.
// - The deceleration curve range is a separate fifteen-bit pre-register.
// - A zero curve range is replaced by half of high feed speed minus initial speed.
// - Unimplemented upper bits of range and speed registers drop writes, read zero.
// - The sixteen-bit correction speed sets correction and zero return reverse speed.
// - The correction speed is scaled by the speed multiplier to give the pulse rate.
// - The curve profile select bit chooses linear or S-curve ramps.
//
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
module maprm_top (
  input  wire logic        SYS_CLK_IN,        // 125 MHz clock
  input  wire logic        RESETN_IN,         // Async reset, active low
  input  wire logic        CLK_EN_IN,         // Freezes all state while low
  input  wire logic [4:0]  AVS_ADDRESS_IN,    // Byte address
  input  wire logic        AVS_READ_IN,       // Read request
  input  wire logic        AVS_WRITE_IN,      // Write request
  input  wire logic [31:0] AVS_WRITEDATA_IN,  // Write data
  input  wire logic [3:0]  AVS_BYTEENABLE_IN, // Byte enables
  output logic      [31:0] AVS_READDATA_OUT,  // Read data, registered
  output logic             AVS_WAITREQUEST_OUT, // Wait request
  input  wire logic [6:0]  OPERATION_KIND_IN, // Operation kind field
  input  wire logic        CURVE_PROFILE_SELECT_IN, // 0 linear, 1 S-curve
  input  wire logic [15:0] HIGH_FEED_SPEED_IN,  // High feed speed
  input  wire logic [15:0] INITIAL_SPEED_IN,    // Start speed
  input  wire logic [15:0] SPEED_MULTIPLIER_IN, // Speed multiplier
  input  wire logic        OP_START_IN,       // Operation start pulse
  input  wire logic        MOVE_NEG_IN,       // Motion direction, 1 negative
  input  wire logic        STEP_IN,           // Step pulse from generator
  input  wire logic        END_LIMIT_INPUT_IN,  // End limit pin
  output logic      [27:0] INTERP_AUX_WORKING_OUT, // Working aux value
  output logic             AUX_IS_MASTER_OUT, // Aux used as master feed
  output logic             AUX_IS_CENTER_OUT, // Aux used as arc centre
  output logic      [14:0] ACCEL_RANGE_OUT,   // Effective accel range
  output logic      [14:0] DECEL_RANGE_OUT,   // Effective decel range
  output logic             S_CURVE_OUT,       // S-curve ramps in use
  output logic      [31:0] CORR_RATE_OUT,     // Correction pulse rate
  output logic             OUT_PIN_OUT,       // Pulse output pin
  output logic             DIR_PIN_OUT,       // Direction output pin
  output logic             LIMIT_STOP_OUT,    // Limit reached, stop request
  output logic             LIMIT_DECEL_OUT    // 1 decel stop, 0 immediate
);

  typedef struct packed {
    logic [27:0] aux_pre;
    logic [27:0] aux_work;
    logic [14:0] acc_pre;
    logic [14:0] acc_work;
    logic [14:0] dec_pre;
    logic [14:0] dec_work;
    logic [15:0] corr_speed;
    logic [7:0]  env_one;
    maprm_pkg::maprm_aux_type aux_mode;
    logic        s_curve;
    logic [31:0] rdata;
    logic        ack;
    logic [31:0] corr_rate;
    logic        out_pin;
    logic        dir_pin;
    logic        lim_s1;
    logic        lim_s2;
    logic        lim_stop;
  } maprm_state_type;

  maprm_state_type st_ff;
  maprm_state_type nxt_st;

  logic [31:0] wmask;
  logic [31:0] merged;
  logic [31:0] cur_word;
  logic [16:0] speed_diff;
  logic [14:0] half_diff;
  logic        uses_aux;
  logic        req;
  logic        take_req;
  logic        start_en;

  // All checks run on the system clock and rest while reset is low
  default clocking chk_cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!RESETN_IN);

  // Byte-lane mask for partial writes
  assign wmask = {{8{AVS_BYTEENABLE_IN[3]}}, {8{AVS_BYTEENABLE_IN[2]}},
                  {8{AVS_BYTEENABLE_IN[1]}}, {8{AVS_BYTEENABLE_IN[0]}}};
  assign req   = AVS_READ_IN | AVS_WRITE_IN;

  // Accepted request and enabled start, shared by the checks
  assign take_req = req & ~st_ff.ack & CLK_EN_IN;
  assign start_en = OP_START_IN & CLK_EN_IN;

  // Half speed difference; saturates at zero when start speed is higher
  assign speed_diff = (HIGH_FEED_SPEED_IN > INITIAL_SPEED_IN) ?
                      ({1'b0, HIGH_FEED_SPEED_IN} - {1'b0, INITIAL_SPEED_IN}) : 17'h0_0000;
  assign half_diff  = speed_diff[15:1];

  // Aux register is meaningful only in the four interpolation kinds
  assign uses_aux = (OPERATION_KIND_IN == maprm_pkg::KIND_CLI2) ||
                    (OPERATION_KIND_IN == maprm_pkg::KIND_LI2)  ||
                    (OPERATION_KIND_IN == maprm_pkg::KIND_CW)   ||
                    (OPERATION_KIND_IN == maprm_pkg::KIND_CCW);

  // Current register word at the addressed offset, used for readback and merges
  always_comb begin
    unique case (AVS_ADDRESS_IN)
      maprm_pkg::OFS_INTERP_AUX:  cur_word = {{4{st_ff.aux_pre[27]}}, st_ff.aux_pre};
      maprm_pkg::OFS_ACCEL_RANGE: cur_word = {17'h0_0000, st_ff.acc_pre};
      maprm_pkg::OFS_DECEL_RANGE: cur_word = {17'h0_0000, st_ff.dec_pre};
      maprm_pkg::OFS_CORR_SPEED:  cur_word = {16'h0000, st_ff.corr_speed};
      maprm_pkg::OFS_ENV_ONE:     cur_word = {24'h00_0000, st_ff.env_one};
      maprm_pkg::OFS_STATUS:      cur_word = {28'h000_0000, st_ff.lim_stop,
                                              st_ff.s_curve, st_ff.aux_mode[2],
                                              st_ff.aux_mode[1]};
      maprm_pkg::OFS_ACCEL_WORK:  cur_word = {17'h0_0000, st_ff.acc_work};
      maprm_pkg::OFS_DECEL_WORK:  cur_word = {17'h0_0000, st_ff.dec_work};
      default:                    cur_word = maprm_pkg::BAD_ADDR;
    endcase
  end

  assign merged = (cur_word & ~wmask) | (AVS_WRITEDATA_IN & wmask);

  // Next-state logic for registers, working copies and pin outputs
  always_comb begin
    nxt_st     = st_ff;
    nxt_st.ack = 1'b0;
    // Bus slave: one wait cycle, then acknowledge
    if (req && !st_ff.ack) begin
      nxt_st.ack   = 1'b1;
      nxt_st.rdata = cur_word;
      if (AVS_WRITE_IN) begin
        unique case (AVS_ADDRESS_IN)
          maprm_pkg::OFS_INTERP_AUX:  nxt_st.aux_pre    = merged[27:0];
          maprm_pkg::OFS_ACCEL_RANGE: nxt_st.acc_pre    = merged[14:0];
          maprm_pkg::OFS_DECEL_RANGE: nxt_st.dec_pre    = merged[14:0];
          maprm_pkg::OFS_CORR_SPEED:  nxt_st.corr_speed = merged[15:0];
          maprm_pkg::OFS_ENV_ONE:     nxt_st.env_one    = merged[7:0];
          default:                    nxt_st.env_one    = st_ff.env_one;
        endcase
      end
    end
    // Latch working registers at operation start
    if (OP_START_IN) begin
      nxt_st.aux_work = uses_aux ? st_ff.aux_pre : 28'h000_0000;
      nxt_st.acc_work = (st_ff.acc_pre == 15'h0000) ? half_diff : st_ff.acc_pre;
      nxt_st.dec_work = (st_ff.dec_pre == 15'h0000) ? half_diff : st_ff.dec_pre;
      nxt_st.s_curve  = CURVE_PROFILE_SELECT_IN;
      if (!uses_aux)
        nxt_st.aux_mode = maprm_pkg::AUX_NONE;
      else if (OPERATION_KIND_IN[2])
        nxt_st.aux_mode = maprm_pkg::AUX_CENTER;
      else
        nxt_st.aux_mode = maprm_pkg::AUX_MASTER;
    end
    // Correction pulse rate, registered product
    nxt_st.corr_rate = st_ff.corr_speed * SPEED_MULTIPLIER_IN;
    // Pulse format on the two output pins
    if (st_ff.env_one[maprm_pkg::ENV_FMT_HI:maprm_pkg::ENV_FMT_LO] ==
        maprm_pkg::FMT_TWO_PULSE) begin
      nxt_st.out_pin = STEP_IN & ~MOVE_NEG_IN;
      nxt_st.dir_pin = STEP_IN &  MOVE_NEG_IN;
    end else begin
      nxt_st.out_pin = STEP_IN;
      nxt_st.dir_pin = (st_ff.env_one[2:1] == maprm_pkg::FMT_INV_HI) ?
                       MOVE_NEG_IN : ~MOVE_NEG_IN;
    end
    // Limit pin synchroniser; stop request follows the second stage only
    nxt_st.lim_s1   = END_LIMIT_INPUT_IN;
    nxt_st.lim_s2   = st_ff.lim_s1;
    nxt_st.lim_stop = st_ff.lim_s2;
  end

  // State register with clock enable
  always_ff @(posedge SYS_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      st_ff          <= '0;
      st_ff.aux_mode <= maprm_pkg::AUX_NONE;
    end else if (CLK_EN_IN) begin
      st_ff <= nxt_st;
    end
  end

  // Outputs
  assign AVS_WAITREQUEST_OUT    = req & ~st_ff.ack;
  assign AVS_READDATA_OUT       = st_ff.rdata;
  assign INTERP_AUX_WORKING_OUT = st_ff.aux_work;
  assign AUX_IS_MASTER_OUT      = st_ff.aux_mode[1];
  assign AUX_IS_CENTER_OUT      = st_ff.aux_mode[2];
  assign ACCEL_RANGE_OUT        = st_ff.acc_work;
  assign DECEL_RANGE_OUT        = st_ff.dec_work;
  assign S_CURVE_OUT            = st_ff.s_curve;
  assign CORR_RATE_OUT          = st_ff.corr_rate;
  assign OUT_PIN_OUT            = st_ff.out_pin;
  assign DIR_PIN_OUT            = st_ff.dir_pin;
  assign LIMIT_STOP_OUT         = st_ff.lim_stop;
  assign LIMIT_DECEL_OUT        = st_ff.env_one[maprm_pkg::ENV_LIMIT];

  // Assertions
  a_aux_sign_ext: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    (AVS_READ_IN && !st_ff.ack && CLK_EN_IN && AVS_ADDRESS_IN == maprm_pkg::OFS_INTERP_AUX)
    |=> (AVS_READDATA_OUT[31:28] == {4{AVS_READDATA_OUT[27]}}))
    else $error("aux readback not sign extended");
  a_range_upper_zero: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    (AVS_READ_IN && !st_ff.ack && CLK_EN_IN && AVS_ADDRESS_IN == maprm_pkg::OFS_ACCEL_RANGE)
    |=> (AVS_READDATA_OUT[31:15] == 17'h0_0000))
    else $error("range upper bits not zero");
  a_aux_unused: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    (OP_START_IN && CLK_EN_IN && !uses_aux) |=> (INTERP_AUX_WORKING_OUT == 28'h000_0000))
    else $error("aux used outside interpolation");
  a_aux_center: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    (OP_START_IN && CLK_EN_IN && (OPERATION_KIND_IN == maprm_pkg::KIND_CW))
    |=> AUX_IS_CENTER_OUT && !AUX_IS_MASTER_OUT)
    else $error("circular kind not centre");
  a_aux_master: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    (OP_START_IN && CLK_EN_IN && (OPERATION_KIND_IN == maprm_pkg::KIND_LI2))
    |=> AUX_IS_MASTER_OUT && (INTERP_AUX_WORKING_OUT == $past(st_ff.aux_pre)))
    else $error("linear 2 kind not master feed");
  a_zero_range: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    (OP_START_IN && CLK_EN_IN && st_ff.acc_pre == 15'h0000) |=> (ACCEL_RANGE_OUT == $past(half_diff)))
    else $error("zero accel range not replaced");
  a_decel_copy: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    (OP_START_IN && CLK_EN_IN && st_ff.dec_pre != 15'h0000) |=> (DECEL_RANGE_OUT == $past(st_ff.dec_pre)))
    else $error("decel range not copied");
  a_corr_rate: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    CLK_EN_IN ##1 CLK_EN_IN |=> (CORR_RATE_OUT == $past(st_ff.corr_speed) * $past(SPEED_MULTIPLIER_IN)))
    else $error("correction rate wrong");
  a_wait_one: assert property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    (req && !st_ff.ack && CLK_EN_IN) |=> !AVS_WAITREQUEST_OUT)
    else $error("waitrequest held too long");

  // Readback of unimplemented bits, unmapped offsets and stored values
  a_decel_upper_zero: assert property (
    take_req && AVS_READ_IN && AVS_ADDRESS_IN == maprm_pkg::OFS_DECEL_RANGE
    |=> AVS_READDATA_OUT[31:15] == 17'h0_0000) else $error("decel upper bits not zero");
  a_speed_upper_zero: assert property (
    take_req && AVS_READ_IN && AVS_ADDRESS_IN == maprm_pkg::OFS_CORR_SPEED
    |=> AVS_READDATA_OUT[31:16] == 16'h0000) else $error("speed upper bits not zero");
  a_env_upper_zero: assert property (
    take_req && AVS_READ_IN && AVS_ADDRESS_IN == maprm_pkg::OFS_ENV_ONE
    |=> AVS_READDATA_OUT[31:8] == 24'h00_0000) else $error("env upper bits not zero");
  a_bad_read_zero: assert property (
    take_req && AVS_READ_IN && AVS_ADDRESS_IN[1:0] != 2'h0
    |=> AVS_READDATA_OUT == maprm_pkg::BAD_ADDR) else $error("unmapped read not zero");
  a_aux_read_value: assert property (
    take_req && AVS_READ_IN && AVS_ADDRESS_IN == maprm_pkg::OFS_INTERP_AUX
    |=> AVS_READDATA_OUT[27:0] == $past(st_ff.aux_pre)) else $error("aux readback wrong");
  a_acc_work_read: assert property (
    take_req && AVS_READ_IN && AVS_ADDRESS_IN == maprm_pkg::OFS_ACCEL_WORK
    |=> AVS_READDATA_OUT[14:0] == $past(st_ff.acc_work)) else $error("accel work read wrong");
  a_dec_work_read: assert property (
    take_req && AVS_READ_IN && AVS_ADDRESS_IN == maprm_pkg::OFS_DECEL_WORK
    |=> AVS_READDATA_OUT[14:0] == $past(st_ff.dec_work)) else $error("decel work read wrong");

  // Full-word writes keep only the implemented bits
  a_aux_write_keep: assert property (
    take_req && AVS_WRITE_IN && &AVS_BYTEENABLE_IN && AVS_ADDRESS_IN == maprm_pkg::OFS_INTERP_AUX
    |=> st_ff.aux_pre == $past(AVS_WRITEDATA_IN[27:0])) else $error("aux write lost");
  a_acc_write_keep: assert property (
    take_req && AVS_WRITE_IN && &AVS_BYTEENABLE_IN && AVS_ADDRESS_IN == maprm_pkg::OFS_ACCEL_RANGE
    |=> st_ff.acc_pre == $past(AVS_WRITEDATA_IN[14:0])) else $error("accel write lost");
  a_dec_write_keep: assert property (
    take_req && AVS_WRITE_IN && &AVS_BYTEENABLE_IN && AVS_ADDRESS_IN == maprm_pkg::OFS_DECEL_RANGE
    |=> st_ff.dec_pre == $past(AVS_WRITEDATA_IN[14:0])) else $error("decel write lost");
  a_speed_write_keep: assert property (
    take_req && AVS_WRITE_IN && &AVS_BYTEENABLE_IN && AVS_ADDRESS_IN == maprm_pkg::OFS_CORR_SPEED
    |=> st_ff.corr_speed == $past(AVS_WRITEDATA_IN[15:0])) else $error("speed write lost");
  a_env_write_keep: assert property (
    take_req && AVS_WRITE_IN && &AVS_BYTEENABLE_IN && AVS_ADDRESS_IN == maprm_pkg::OFS_ENV_ONE
    |=> st_ff.env_one == $past(AVS_WRITEDATA_IN[7:0])) else $error("env write lost");
  a_work_readonly: assert property (
    take_req && AVS_WRITE_IN && !OP_START_IN && AVS_ADDRESS_IN == maprm_pkg::OFS_ACCEL_WORK
    |=> $stable(st_ff.acc_work)) else $error("working register written by bus");
  a_read_no_change: assert property (
    take_req && AVS_READ_IN && !AVS_WRITE_IN
    |=> $stable(st_ff.aux_pre) && $stable(st_ff.corr_speed)) else $error("read changed a register");

  // Bus handshake shape
  a_ack_pulse: assert property (
    st_ff.ack && CLK_EN_IN |=> !st_ff.ack) else $error("acknowledge longer than one cycle");
  a_rdata_hold: assert property (
    !(req && !st_ff.ack) |=> $stable(AVS_READDATA_OUT)) else $error("read data moved while idle");
  a_freeze_low: assert property (
    !CLK_EN_IN |=> $stable(st_ff)) else $error("state moved while clock enable low");

  // Working copies load only at a start
  a_aux_copy: assert property (
    start_en && uses_aux |=> INTERP_AUX_WORKING_OUT == $past(st_ff.aux_pre))
    else $error("aux not copied at start");
  a_work_hold: assert property (
    !start_en |=> $stable(INTERP_AUX_WORKING_OUT) && $stable(ACCEL_RANGE_OUT))
    else $error("working register moved without start");
  a_accel_copy: assert property (
    start_en && st_ff.acc_pre != 15'h0000 |=> ACCEL_RANGE_OUT == $past(st_ff.acc_pre))
    else $error("accel range not copied");
  a_decel_zero: assert property (
    start_en && st_ff.dec_pre == 15'h0000 |=> DECEL_RANGE_OUT == $past(half_diff))
    else $error("zero decel range not replaced");
  a_aux_ccw: assert property (
    start_en && OPERATION_KIND_IN == maprm_pkg::KIND_CCW |=> AUX_IS_CENTER_OUT && !AUX_IS_MASTER_OUT)
    else $error("ccw kind not centre");
  a_aux_cont_master: assert property (
    start_en && OPERATION_KIND_IN == maprm_pkg::KIND_CLI2 |=> AUX_IS_MASTER_OUT && !AUX_IS_CENTER_OUT)
    else $error("continuous linear 2 kind not master feed");
  a_mode_onehot: assert property (
    $onehot(st_ff.aux_mode)) else $error("aux mode not one-hot");
  a_curve_select: assert property (
    start_en |=> S_CURVE_OUT == $past(CURVE_PROFILE_SELECT_IN)) else $error("curve select not taken");
  a_curve_hold: assert property (
    !start_en |=> $stable(S_CURVE_OUT)) else $error("curve select moved without start");

  // Pulse pins follow the selected format one cycle later
  a_fmt_two_pulse: assert property (
    CLK_EN_IN && st_ff.env_one[2:0] == maprm_pkg::FMT_TWO_PULSE
    |=> OUT_PIN_OUT == $past(STEP_IN & ~MOVE_NEG_IN) && DIR_PIN_OUT == $past(STEP_IN & MOVE_NEG_IN))
    else $error("two-pulse pins wrong");
  a_fmt_inverted: assert property (
    CLK_EN_IN && st_ff.env_one[2:1] == maprm_pkg::FMT_INV_HI
    |=> DIR_PIN_OUT == $past(MOVE_NEG_IN)) else $error("inverted direction wrong");
  a_fmt_plain: assert property (
    CLK_EN_IN && !st_ff.env_one[maprm_pkg::ENV_FMT_HI] && st_ff.env_one[2:1] != maprm_pkg::FMT_INV_HI
    |=> DIR_PIN_OUT == !$past(MOVE_NEG_IN)) else $error("plain direction wrong");
  a_fmt_out_step: assert property (
    CLK_EN_IN && st_ff.env_one[2:0] != maprm_pkg::FMT_TWO_PULSE
    |=> OUT_PIN_OUT == $past(STEP_IN)) else $error("pulse pin does not follow step");

  // The limit pin reaches the stop request after three enabled edges
  a_limit_delay: assert property (
    CLK_EN_IN ##1 CLK_EN_IN ##1 CLK_EN_IN |=> LIMIT_STOP_OUT == $past(END_LIMIT_INPUT_IN, 3))
    else $error("limit stop delay wrong");

  // Scenario covers
  c_zero_range: cover property (start_en && st_ff.acc_pre == 15'h0000);
  c_limit_stop: cover property ($rose(LIMIT_STOP_OUT));

  c_write_aux: cover property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    AVS_WRITE_IN && !AVS_WAITREQUEST_OUT && AVS_ADDRESS_IN == maprm_pkg::OFS_INTERP_AUX);
  c_start_circ: cover property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    OP_START_IN && OPERATION_KIND_IN == maprm_pkg::KIND_CCW);
  c_two_pulse: cover property (@(posedge SYS_CLK_IN) disable iff (!RESETN_IN)
    st_ff.env_one[2:0] == maprm_pkg::FMT_TWO_PULSE && STEP_IN);

endmodule : maprm_top

/* verif/maprm_motor_model.sv */
// Driver model at the far side: counts step pulses seen on the pulse pin
module maprm_motor_model (
  input  wire logic        clk_in,    // System clock
  input  wire logic        pulse_in,  // Pulse pin from the axis
  input  wire logic        dir_in,    // Direction pin from the axis
  output logic      [15:0] steps_out  // Rising pulse edges seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pulse_q = 1'b0;
  logic dir_q   = 1'b0;
  initial steps_out = 16'h0000;
  // Count rising edges only, a held level is one step
  always @(posedge clk_in) begin
    pulse_q <= pulse_in;
    dir_q   <= dir_in; // Kept for waveform reading only
    if (pulse_in && !pulse_q) steps_out <= steps_out + 16'h0001;
  end
endmodule : maprm_motor_model

/* verif/maprm_top_bench.sv */
// Self-checking bench of the axis parameter registers
module maprm_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, csel = 1'b0;
  logic start = 1'b0, neg = 1'b0, step = 1'b0, lim = 1'b0;
  logic [4:0] addr = 5'h00;
  logic [31:0] wdata = 32'h0, rdata, rate, q, d;
  logic [3:0] be = 4'hf;
  logic [6:0] kind = 7'h00;
  logic [15:0] hfs = 16'h0, ispd = 16'h0, mult = 16'h0, steps, s0;
  logic [27:0] aux_w;
  logic [14:0] acc_r, dec_r;
  logic waitreq, is_m, is_c, scurve, out_p, dir_p, lstop, ldec;
  int failures = 0, n_compared = 0;
  always #4 clk = ~clk;
  maprm_top uut (.SYS_CLK_IN(clk), .RESETN_IN(rst_n), .CLK_EN_IN(1'b1),
    .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr), .AVS_WRITEDATA_IN(wdata),
    .AVS_BYTEENABLE_IN(be), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq),
    .OPERATION_KIND_IN(kind), .CURVE_PROFILE_SELECT_IN(csel), .HIGH_FEED_SPEED_IN(hfs),
    .INITIAL_SPEED_IN(ispd), .SPEED_MULTIPLIER_IN(mult), .OP_START_IN(start),
    .MOVE_NEG_IN(neg), .STEP_IN(step), .END_LIMIT_INPUT_IN(lim),
    .INTERP_AUX_WORKING_OUT(aux_w), .AUX_IS_MASTER_OUT(is_m), .AUX_IS_CENTER_OUT(is_c),
    .ACCEL_RANGE_OUT(acc_r), .DECEL_RANGE_OUT(dec_r), .S_CURVE_OUT(scurve),
    .CORR_RATE_OUT(rate), .OUT_PIN_OUT(out_p), .DIR_PIN_OUT(dir_p),
    .LIMIT_STOP_OUT(lstop), .LIMIT_DECEL_OUT(ldec));
  maprm_motor_model drv (.clk_in(clk), .pulse_in(out_p), .dir_in(dir_p), .steps_out(steps));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Avalon master: hold the request until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] v,
                     input logic [3:0] b, output logic [31:0] r);
    bit done;
    done = 0;
    r = 32'h0;
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= v;
    be <= b;
    for (int i = 0; i < 40 && !done; i++) begin
      @(posedge clk);
      done = (waitreq === 1'b0);
      r = rdata;
    end
    if (!done) chk("bus answer", 32'h1, 32'h0);
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk); // One idle edge so no signal is driven twice in a step
  endtask : bus
  task automatic wreg(input logic [4:0] a, input logic [31:0] v);
    bus(1'b1, a, v, 4'hf, q);
  endtask : wreg
  task automatic rchk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf, q);
    chk($sformatf("reg %h", a), e, q);
  endtask : rchk
  task automatic op_start(input logic [6:0] k);
    kind <= k;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask : op_start
  // Zero range falls back to half the speed span, clipped at zero
  function automatic logic [31:0] exp_rng(logic [31:0] p, logic [15:0] h, logic [15:0] s);
    logic [15:0] half;
    half = (s >= h) ? 16'h0 : (h - s) >> 1;
    return (p[14:0] != 15'h0) ? {17'h0, p[14:0]} : {17'h0, half[14:0]};
  endfunction : exp_rng
  function automatic logic exp_dir(logic [2:0] f, logic n, logic s);
    if (f == maprm_pkg::FMT_TWO_PULSE) return s & n;
    return (f[2:1] == maprm_pkg::FMT_INV_HI) ? n : ~n;
  endfunction : exp_dir
  logic [6:0] kinds [6] = '{7'h61, 7'h00, 7'h62, 7'h63, 7'h65, 7'h64};
  logic [4:0] ofs [4] = '{5'h04, 5'h08, 5'h0c, 5'h10};
  logic [31:0] msk [4] = '{32'h7fff, 32'h7fff, 32'hffff, 32'hff};
  initial begin
    void'($urandom(54754));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int a = 0; a < 8; a++) rchk(5'(a * 4), maprm_pkg::RST_WORD);
    // Sign extension from bit 27, both signs at the boundary first
    for (int i = 0; i < 6; i++) begin
      d = (i == 0) ? 32'h0800_0000 : (i == 1) ? 32'hf7ff_ffff : $urandom();
      wreg(maprm_pkg::OFS_INTERP_AUX, d);
      rchk(maprm_pkg::OFS_INTERP_AUX, {{4{d[27]}}, d[27:0]});
    end
    for (int i = 0; i < 4; i++) begin
      d = $urandom();
      wreg(ofs[i], d);
      rchk(ofs[i], d & msk[i]);
    end
    wreg(maprm_pkg::OFS_CORR_SPEED, 32'h0000_1200);
    bus(1'b1, maprm_pkg::OFS_CORR_SPEED, 32'hffff_ffff, 4'h1, q);
    rchk(maprm_pkg::OFS_CORR_SPEED, 32'h0000_12ff);
    rchk(5'h01, maprm_pkg::BAD_ADDR);
    wreg(maprm_pkg::OFS_ACCEL_WORK, 32'h1234);
    rchk(maprm_pkg::OFS_ACCEL_WORK, 32'h0);
    // Six kinds, the aux kinds last so the preload check follows a circular start
    for (int i = 0; i < 6; i++) begin
      d = $urandom();
      wreg(maprm_pkg::OFS_INTERP_AUX, d);
      op_start(kinds[i]);
      chk("aux work", (i > 1) ? {4'h0, d[27:0]} : 32'h0, {4'h0, aux_w});
      chk("master", (i == 2 || i == 3), is_m);
      chk("center", (i > 3), is_c);
      @(posedge clk);
    end
    wreg(maprm_pkg::OFS_INTERP_AUX, ~d);
    chk("aux held", {4'h0, d[27:0]}, {4'h0, aux_w});
    for (int i = 0; i < 6; i++) begin
      d = (i % 3 == 0) ? 32'h0 : $urandom();
      hfs <= 16'($urandom());
      ispd <= 16'($urandom());
      csel <= i[0];
      @(posedge clk);
      if (i == 3) ispd <= hfs;
      wreg(maprm_pkg::OFS_ACCEL_RANGE, d);
      wreg(maprm_pkg::OFS_DECEL_RANGE, d ^ 32'h1);
      op_start(7'h00);
      chk("accel", exp_rng(d, hfs, ispd), {17'h0, acc_r});
      chk("decel", exp_rng(d ^ 32'h1, hfs, ispd), {17'h0, dec_r});
      chk("s curve", csel, scurve);
      @(posedge clk);
      rchk(maprm_pkg::OFS_ACCEL_WORK, exp_rng(d, hfs, ispd));
    end
    d = $urandom();
    wreg(maprm_pkg::OFS_CORR_SPEED, d);
    s0 = 16'($urandom());
    mult <= s0;
    repeat (3) @(posedge clk);
    chk("rate", d[15:0] * s0, rate);
    // Each pulse format, both directions; two-pulse forward must reach the driver
    for (int f = 0; f < 5; f++) begin
      for (int n = 0; n < 2; n++) begin
        wreg(maprm_pkg::OFS_ENV_ONE, 32'(f));
        s0 = steps;
        neg <= n[0];
        step <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        chk("dir", exp_dir(3'(f), n[0], 1'b1), dir_p);
        if (f == 4) chk("out", !n[0], out_p);
        @(posedge clk);
        step <= 1'b0;
        repeat (2) @(posedge clk);
        if (f == 4 && n == 0) chk("steps", s0 + 16'h1, steps);
      end
    end
    wreg(maprm_pkg::OFS_ENV_ONE, 32'h08);
    lim <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("limit stop", 1'b1, lstop);
    chk("limit decel", 1'b1, ldec);
    final_report();
  end
  initial begin
    #400000;
    failures++;
    final_report();
  end
  task automatic final_report();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
endmodule : maprm_top_bench
